/* File: fp_stack.v */
// Legacy numeric register stack held in native float registers, plus status
`timescale 1ns/1ns
`include "intercept_regs.vh"
module fp_stack #(
  parameter DEPTH = `FP_STACK_DEPTH
) (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Numeric result
  input wire wr_en,
  input wire [2:0] st_idx,
  input wire [15:0] status_in,
  // Observed state
  output reg [6:0] native_reg,
  output reg [15:0] fp_status_reg
);
  reg [2:0] top_r;
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      top_r <= 3'h0;
      native_reg <= `FP_STACK_BASE;
      fp_status_reg <= 16'h0000;
    end else if (wr_en) begin
      // Stack slot maps onto f8-f15, wrapping as the legacy stack does
      native_reg <= `FP_STACK_BASE + {4'h0, top_r + st_idx}; // see (RULE12)
      fp_status_reg <= {status_in[15:14], top_r, status_in[10:0]}; // see (RULE13)
    end
  end
endmodule // fp_stack

/* File: instr_classify.v */
// Classifier that maps a legacy instruction code to its intercept outcome
`timescale 1ns/1ns
`include "intercept_regs.vh"
module instr_classify (
  // Instruction
  input wire [4:0] op,
  input wire taken,
  input wire gate,
  input wire lock_prefix,
  input wire lock_external,
  input wire [7:0] imm_vec,
  // Controls
  input wire tb_en,
  input wire lock_dis,
  // Outcome
  output reg [`EV_W-1:0] events,
  output reg [7:0] vector
);
  always @* begin
    events = {`EV_W{1'b0}};
    vector = 8'h00;
    case (op)
      `OP_HALT, `OP_CACHE_INV, `OP_PAGE_INV, `OP_LOAD_IDT, `OP_LOAD_GDT,
      `OP_LOAD_LDT, `OP_LOAD_MSW, `OP_LOAD_TR: events[`EV_INSTR] = 1'b1; // see (RULE1)
      `OP_INTERRUPT_RETURN_INSTR: events[`EV_INSTR] = 1'b1; // see (RULE2)
      `OP_INT3: begin
        events[`EV_LINT] = 1'b1; // see (RULE5)
        vector = `VEC_BREAKPOINT;
      end
      `OP_INTO: begin
        events[`EV_LINT] = taken; // see (RULE5)
        vector = `VEC_OVERFLOW;
      end
      `OP_INTN: begin
        events[`EV_LEXC] = 1'b1; // see (RULE6)
        vector = imm_vec;
      end
      `OP_JCC, `OP_LOOP, `OP_JMP_DIRECT: events[`EV_TBTRAP] = tb_en & taken; // see (RULE7) (RULE9)
      `OP_JMP_GATE: events[`EV_GATE] = 1'b1; // see (RULE8)
      `OP_JMP_NATIVE: events[`EV_ISA] = 1'b1; // see (RULE10)
      default: events = {`EV_W{1'b0}}; // see (RULE14)
    endcase
    // Lock check applies to any prefixed instruction, on top of its class
    if (lock_prefix && lock_dis && lock_external) begin
      events[`EV_LOCK] = 1'b1; // see (RULE11)
    end
  end
endmodule // instr_classify

/* File: intercept_regs.vh */
// Register offsets, fields, codes and constants of the legacy intercept unit
// Notes on behaviour
// (RULE1) Privileged legacy system instructions raise instruction intercept
// (RULE2) Every interrupt-return form raises instruction intercept
// (RULE3) Port input maps through virtual translation faults
// (RULE4) io_check_enable zero skips task-state bitmap check
// (RULE5) Breakpoint and overflow deliver legacy interrupt vector
// (RULE6) Software interrupt n delivers legacy exception vector
// (RULE7) Taken branch trap when enable set
// (RULE8) Jump through gate raises gate intercept
// (RULE9) Direct near and far jumps run unchanged
// (RULE10) Jump-to-native switches to native instruction set
// (RULE11) Lock prefix intercepts if locks disabled, external
// (RULE12) Numeric stack lives in native f8-f15
// (RULE13) Numeric results recorded in fp_status_reg
// (RULE14) Other legacy instructions behave unchanged
`ifndef INTERCEPT_REGS_VH
`define INTERCEPT_REGS_VH
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_MASK 12'h008
`define REG_LAST 12'h00C
`define REG_COUNT 12'h010
`define REG_FPSTAT 12'h014
`define CTRL_IO_CHECK 0
`define CTRL_TB_EN 1
`define CTRL_LOCK_DIS 2
`define CTRL_RESET 32'h00000000
`define EV_INSTR 0
`define EV_GATE 1
`define EV_LOCK 2
`define EV_TBTRAP 3
`define EV_LINT 4
`define EV_LEXC 5
`define EV_ISA 6
`define EV_IOFAULT 7
`define EV_W 8
`define OP_OTHER 5'h00
`define OP_HALT 5'h01
`define OP_CACHE_INV 5'h02
`define OP_PAGE_INV 5'h03
`define OP_LOAD_IDT 5'h04
`define OP_LOAD_GDT 5'h05
`define OP_LOAD_LDT 5'h06
`define OP_LOAD_MSW 5'h07
`define OP_LOAD_TR 5'h08
`define OP_INTERRUPT_RETURN_INSTR 5'h09
`define OP_PORT_IN 5'h0A
`define OP_INT3 5'h0B
`define OP_INTO 5'h0C
`define OP_INTN 5'h0D
`define OP_JCC 5'h0E
`define OP_JMP_DIRECT 5'h0F
`define OP_JMP_GATE 5'h10
`define OP_LOOP 5'h11
`define OP_JMP_NATIVE 5'h12
`define OP_NUMERIC 5'h13
`define VEC_BREAKPOINT 8'h03
`define VEC_OVERFLOW 8'h04
`define FP_STACK_BASE 7'h08
`define FP_STACK_DEPTH 8
`endif

/* File: legacy_isa_intercept_unit.v */
// Top of the legacy instruction intercept unit with its APB register file
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "intercept_regs.vh"
module legacy_isa_intercept_unit (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Retiring legacy instruction
  input wire instr_valid,
  input wire [4:0] instr_op,
  input wire instr_taken,
  input wire instr_gate,
  input wire instr_lock,
  input wire instr_lock_ext,
  input wire [7:0] instr_vec,
  input wire port_tlb_fault,
  input wire [2:0] fp_idx,
  input wire [15:0] fp_result_status,
  // Outcome
  output reg intercept_r,
  output reg [`EV_W-1:0] event_r,
  output reg [7:0] vector_r,
  output reg io_bitmap_check_r,
  output reg native_isa_r,
  output reg [6:0] fp_native_reg,
  output reg [15:0] fp_status,
  output reg irq
);
  reg [31:0] ctrl_r;
  reg [`EV_W-1:0] status_r;
  reg [`EV_W-1:0] mask_r;
  reg [15:0] count_r;
  wire [`EV_W-1:0] cls_events;
  wire [7:0] cls_vec;
  wire [6:0] fp_reg_w;
  wire [15:0] fp_stat_w;
  reg [`EV_W-1:0] ev_nxt;
  reg [`EV_W-1:0] status_nxt;
  wire wr_acc;
  wire rd_acc;
  wire is_numeric;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~pwrite;
  assign is_numeric = instr_valid && instr_op == `OP_NUMERIC;

  instr_classify u_cls (
    .op(instr_op),
    .taken(instr_taken),
    .gate(instr_gate),
    .lock_prefix(instr_lock),
    .lock_external(instr_lock_ext),
    .imm_vec(instr_vec),
    .tb_en(ctrl_r[`CTRL_TB_EN]),
    .lock_dis(ctrl_r[`CTRL_LOCK_DIS]),
    .events(cls_events),
    .vector(cls_vec)
  );

  fp_stack #(.DEPTH(`FP_STACK_DEPTH)) u_fp (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(is_numeric),
    .st_idx(fp_idx),
    .status_in(fp_result_status),
    .native_reg(fp_reg_w),
    .fp_status_reg(fp_stat_w)
  );

  function legal_addr;
    input [11:0] a;
    begin
      legal_addr = (a == `REG_CTRL) || (a == `REG_STATUS) || (a == `REG_MASK) ||
                   (a == `REG_LAST) || (a == `REG_COUNT) || (a == `REG_FPSTAT);
    end
  endfunction

  always @* begin
    ev_nxt = {`EV_W{1'b0}};
    if (instr_valid) begin
      ev_nxt = cls_events;
      // Port input runs as usual but faults come from translation only
      if (instr_op == `OP_PORT_IN) begin
        ev_nxt[`EV_IOFAULT] = port_tlb_fault; // see (RULE3)
      end
    end
    // Set wins over a write-one clear in the same cycle
    status_nxt = status_r;
    if (wr_acc && paddr == `REG_STATUS) begin
      status_nxt = status_r & ~pwdata[`EV_W-1:0];
    end
    status_nxt = status_nxt | ev_nxt;
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_r <= `CTRL_RESET;
      status_r <= {`EV_W{1'b0}};
      mask_r <= {`EV_W{1'b0}};
      count_r <= 16'h0000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      intercept_r <= 1'b0;
      event_r <= {`EV_W{1'b0}};
      vector_r <= 8'h00;
      io_bitmap_check_r <= 1'b0;
      native_isa_r <= 1'b0;
      fp_native_reg <= 7'h00;
      fp_status <= 16'h0000;
      irq <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq <= |(status_nxt & mask_r);
      event_r <= ev_nxt;
      intercept_r <= |ev_nxt[`EV_LOCK:`EV_INSTR];
      vector_r <= (ev_nxt[`EV_LINT] | ev_nxt[`EV_LEXC]) ? cls_vec : 8'h00;
      // Bitmap only consulted when software asks for it
      io_bitmap_check_r <= instr_valid && instr_op == `OP_PORT_IN &&
                           ctrl_r[`CTRL_IO_CHECK]; // see (RULE4)
      if (ev_nxt[`EV_ISA]) begin
        native_isa_r <= 1'b1; // see (RULE10)
      end else if (instr_valid) begin
        native_isa_r <= 1'b0;
      end
      if (|ev_nxt && count_r != 16'hFFFF) begin
        count_r <= count_r + 16'h0001;
      end
      fp_native_reg <= fp_reg_w;
      fp_status <= fp_stat_w;
      // No wait state: ready pulses once per access phase
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~legal_addr(paddr);
      if (wr_acc && pready) begin
        if (paddr == `REG_CTRL) begin
          ctrl_r <= {29'h0, pwdata[2:0]};
        end
        if (paddr == `REG_MASK) begin
          mask_r <= pwdata[`EV_W-1:0];
          irq <= |(status_nxt & pwdata[`EV_W-1:0]);
        end
      end
      if (rd_acc && ~penable) begin
        case (paddr)
          `REG_CTRL: prdata <= ctrl_r;
          `REG_STATUS: prdata <= {24'h0, status_r};
          `REG_MASK: prdata <= {24'h0, mask_r};
          `REG_LAST: prdata <= {16'h0, vector_r, event_r};
          `REG_COUNT: prdata <= {16'h0, count_r};
          `REG_FPSTAT: prdata <= {9'h0, fp_native_reg, fp_status};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // legacy_isa_intercept_unit

/* File: legacy_isa_intercept_unit_asserts.sv */
// Port checker for the legacy intercept unit
`timescale 1ns/1ns
`include "intercept_regs.vh"
module intercept_chk (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // APB
  input wire psel,
  input wire penable,
  input wire pready,
  // Instruction and outcome
  input wire instr_valid,
  input wire [4:0] instr_op,
  input wire [7:0] instr_vec,
  input wire intercept_r,
  input wire [`EV_W-1:0] event_r,
  input wire [7:0] vector_r,
  input wire native_isa_r,
  input wire [6:0] fp_native_reg
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire iv = instr_valid;
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready is not a one cycle answer");
  a_priv_intercept: assert property (iv && instr_op inside {[`OP_HALT:`OP_LOAD_TR]}
    |=> intercept_r && event_r[`EV_INSTR]) else $error("privileged op not intercepted");
  a_interrupt_return_instr_intercept: assert property (iv && instr_op == `OP_INTERRUPT_RETURN_INSTR
    |=> intercept_r && event_r[`EV_INSTR]) else $error("return not intercepted");
  a_bkpt_vector: assert property (iv && instr_op == `OP_INT3
    |=> event_r[`EV_LINT] && vector_r == `VEC_BREAKPOINT) else $error("breakpoint vector");
  a_swint_vector: assert property (iv && instr_op == `OP_INTN
    |=> event_r[`EV_LEXC] && vector_r == $past(instr_vec)) else $error("soft int vector");
  a_gate_fault: assert property (iv && instr_op == `OP_JMP_GATE
    |=> intercept_r && event_r[`EV_GATE]) else $error("gate jump not faulted");
  a_native_switch: assert property (iv && instr_op == `OP_JMP_NATIVE
    |=> native_isa_r && event_r[`EV_ISA]) else $error("no switch to native");
  a_fp_window: assert property (fp_native_reg != 7'h00 |-> fp_native_reg[6:3] == 4'h1)
    else $error("stack register outside f8 to f15");
endmodule // intercept_chk
bind legacy_isa_intercept_unit intercept_chk u_chk (.*);

/* File: legacy_isa_intercept_unit_tb_top.sv */
// Self-checking bench for the legacy intercept unit
`timescale 1ns/1ns
`include "intercept_regs.vh"
module legacy_isa_intercept_unit_tb_top;
  reg sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg instr_valid = 1'b0, instr_taken = 1'b0, instr_lock = 1'b0, instr_lock_ext = 1'b0;
  reg instr_gate = 1'b0, port_tlb_fault = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000, rd;
  reg [4:0] instr_op = 5'h00;
  reg [7:0] instr_vec = 8'h00;
  reg [2:0] fp_idx = 3'h3;
  reg [15:0] fp_result_status = 16'hFFFF;
  wire [31:0] prdata;
  wire [7:0] event_r, vector_r;
  wire [6:0] fp_native_reg;
  wire [15:0] fp_status;
  wire pready, pslverr, intercept_r, io_bitmap_check_r, native_isa_r, irq;
  integer err_count = 0, n_checks = 0, i, k, w;
  reg err;
  always #5 sys_clk = ~sys_clk;
  legacy_isa_intercept_unit DUT (.*);
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Holds the request until pready is seen high at a rising edge
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // Own wait counter so the scenario loops that call this task keep theirs
    for (w = 0; w < 20 && pready !== 1'b1; w++) @(posedge sys_clk);
    if (w == 20) begin
      err_count++;
      final_report;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Outcome pulse stands for the cycle after the edge that takes the instruction
  task ins(input [4:0] op, input t, input l, input x, input [7:0] v, input f);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    {instr_op, instr_taken, instr_lock, instr_lock_ext, instr_vec} <= {op, t, l, x, v};
    port_tlb_fault <= f;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task out(input string nm, input [16:0] exp);
    chk(nm, {intercept_r, vector_r, event_r}, exp);
  endtask
  task irqchk(input exp);
    repeat (2) @(posedge sys_clk);
    chk("irq", irq, exp);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl", rd, `CTRL_RESET);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slverr", err, 1);
    chk("unmapped", rd, 0);
    $display("register test done");
    apb(1'b1, `REG_MASK, 32'hFFFFFFFF);
    for (i = `OP_HALT; i <= `OP_INTERRUPT_RETURN_INSTR; i++) begin
      ins(i[4:0], 0, 0, 0, 8'h00, 0);
      out("priv", {1'b1, 8'h00, 8'h01 << `EV_INSTR});
    end
    ins(`OP_INT3, 0, 0, 0, 8'h00, 0);
    out("int3", {1'b0, `VEC_BREAKPOINT, 8'h01 << `EV_LINT});
    ins(`OP_INTO, 1, 0, 0, 8'h00, 0);
    out("into", {1'b0, `VEC_OVERFLOW, 8'h01 << `EV_LINT});
    ins(`OP_INTN, 0, 0, 0, 8'h21, 0);
    out("intn", {1'b0, 8'h21, 8'h01 << `EV_LEXC});
    ins(`OP_JMP_GATE, 0, 0, 0, 8'h00, 0);
    out("gate", {1'b1, 8'h00, 8'h01 << `EV_GATE});
    ins(`OP_JMP_NATIVE, 0, 0, 0, 8'h00, 0);
    out("isa", {1'b0, 8'h00, 8'h01 << `EV_ISA});
    ins(`OP_OTHER, 0, 0, 0, 8'h00, 0);
    chk("native clr", native_isa_r, 0);
    out("other", 0);
    $display("intercept test done");
    for (k = 0; k < 2; k++) begin
      apb(1'b1, `REG_CTRL, k ? 32'h0 : 32'h7);
      for (i = 0; i < 3; i++) begin
        ins(i == 0 ? `OP_JCC : i == 1 ? `OP_JMP_DIRECT : `OP_LOOP, 1, 0, 0, 8'h00, 0);
        out("branch", {1'b0, 8'h00, k ? 8'h00 : 8'h01 << `EV_TBTRAP});
      end
      ins(`OP_JCC, 0, 0, 0, 8'h00, 0);
      out("not taken", 0);
      ins(`OP_OTHER, 0, 1, 1, 8'h00, 0);
      out("lock", {k ? 1'b0 : 1'b1, 8'h00, k ? 8'h00 : 8'h01 << `EV_LOCK});
      ins(`OP_OTHER, 0, 1, 0, 8'h00, 0);
      out("lock int", 0);
      ins(`OP_PORT_IN, 0, 0, 0, 8'h00, 0);
      chk("bitmap", io_bitmap_check_r, !k);
    end
    ins(`OP_PORT_IN, 0, 0, 0, 8'h00, 1);
    out("io fault", {1'b0, 8'h00, 8'h01 << `EV_IOFAULT});
    ins(`OP_NUMERIC, 0, 0, 0, 8'h00, 0);
    @(posedge sys_clk);
    chk("fp reg", fp_native_reg, `FP_STACK_BASE + 7'h03);
    chk("fp status", fp_status, 16'hC7FF);
    $display("control test done");
    // A mask bit of one lets its status bit reach the interrupt line
    irqchk(1);
    apb(1'b1, `REG_STATUS, 32'hFF);
    apb(1'b1, `REG_MASK, 32'h0);
    irqchk(0);
    ins(`OP_HALT, 0, 0, 0, 8'h00, 0);
    irqchk(0);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("status", rd, 32'h1 << `EV_INSTR);
    apb(1'b1, `REG_MASK, 32'h1 << `EV_INSTR);
    irqchk(1);
    apb(1'b1, `REG_STATUS, 32'h1 << `EV_INSTR);
    irqchk(0);
    apb(1'b1, `REG_MASK, 32'h0);
    irqchk(0);
    $display("interrupt test done");
    final_report;
  end
endmodule // legacy_isa_intercept_unit_tb_top
